// [hdl/smcg_top.sv]
// Sleep mode control and per-peripheral clock gating with an Avalon-MM register slave.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module smcg_top
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Core handshake.
  input  wire logic        sleep_instr,
  input  wire logic        wake_irq,
  input  wire logic        watchdog_on,
  input  wire logic [1:0]  brownout_sleep_fuse,
  input  wire logic [1:0]  brownout_active_fuse,
  input  wire logic [7:0]  wake_pin_mask,
  input  wire logic        periph_access,
  input  wire logic [2:0]  periph_select,
  // Clock enables and the peripheral access permit.
  output logic             clk_cpu_en,
  output logic             clk_flash_en,
  output logic             clk_io_en,
  output logic             clk_conv_en,
  output logic             osc_en,
  output logic [7:0]       periph_clk_en,
  output logic             periph_access_ok,
  // Analog and housekeeping controls.
  output logic             converter_en,
  output logic             converter_extended,
  output logic             comparator_en,
  output logic             vref_en,
  output logic             brownout_en,
  output logic             brownout_sampled,
  output logic             watchdog_run,
  output logic [7:0]       input_buf_en,
  output logic             core_stall,
  output logic             asleep
);

  typedef enum logic [3:0]
  {
    SMCG_ACTIVE = 4'b0001,
    SMCG_SLEEP  = 4'b0010,
    SMCG_WAKE   = 4'b0100,
    SMCG_STALL  = 4'b1000
  } smcg_state_t;

  smcg_state_t state;
  smcg_state_t next_state;

  logic [7:0] core_sleep_control;
  logic [7:0] peripheral_clock_gate;
  logic [7:0] analog_config;
  logic       conv_was_off;
  logic       wake_start;
  logic [5:0] wake_load;
  logic       wake_done;
  logic [7:0] cell_clk_en;
  logic [7:0] cell_access_ok;
  logic       answer_pending;

  // Decoding.
  wire        sleep_enable      = core_sleep_control[smcg_pkg::SLEEP_ENABLE_BIT];
  wire [1:0]  sleep_mode_select = core_sleep_control[smcg_pkg::SLEEP_MODE_LSB +: 2];
  wire        gate_converter    = peripheral_clock_gate[smcg_pkg::GATE_CONVERTER];
  wire        in_sleep          = (state != SMCG_ACTIVE);
  wire        mode_idle         = (sleep_mode_select == smcg_pkg::MODE_IDLE);
  wire        mode_noise        = (sleep_mode_select == smcg_pkg::MODE_NOISE_RED);
  wire        mode_standby      = (sleep_mode_select == smcg_pkg::MODE_STANDBY);
  wire        mode_deep         = in_sleep && !mode_idle && !mode_noise;
  wire        sel_core          = (avs_address == smcg_pkg::ADDR_CORE_SLEEP_CONTROL);
  wire        sel_gate          = (avs_address == smcg_pkg::ADDR_PERIPHERAL_GATE);
  wire        sel_status        = (avs_address == smcg_pkg::ADDR_SLEEP_STATUS);
  wire        sel_analog        = (avs_address == smcg_pkg::ADDR_ANALOG_CONFIG);
  wire        wr_ok             = avs_write && answer_pending && avs_byteenable[0];
  wire        conv_req          = analog_config[smcg_pkg::ACFG_CONVERTER_ON];
  wire        comp_req          = analog_config[smcg_pkg::ACFG_COMPARATOR_ON];
  wire        comp_ref          = analog_config[smcg_pkg::ACFG_COMPARATOR_REF];

  // Clock domain activity for the current mode.
  wire next_cpu   = !in_sleep;
  wire next_io    = !in_sleep || (state == SMCG_SLEEP && mode_idle);
  wire next_conv  = !in_sleep || (state == SMCG_SLEEP && (mode_idle || mode_noise));
  wire next_osc   = !(state == SMCG_SLEEP && !mode_idle && !mode_noise && !mode_standby);
  wire periph_run = next_io;

  // Comparator is off while asleep in the deep modes and whenever the converter gate bit is set.
  wire next_comp  = comp_req && !(state == SMCG_SLEEP && (mode_deep)) && !gate_converter;
  wire bod_sleep  = (brownout_sleep_fuse == smcg_pkg::BOD_ENABLED) || (brownout_sleep_fuse == smcg_pkg::BOD_SAMPLED);
  wire bod_act    = (brownout_active_fuse == smcg_pkg::BOD_ENABLED) || (brownout_active_fuse == smcg_pkg::BOD_SAMPLED);
  wire use_sleep_fuse = in_sleep && !mode_idle;
  wire next_bod   = use_sleep_fuse ? bod_sleep : bod_act;
  wire [1:0] bod_fuse = use_sleep_fuse ? brownout_sleep_fuse : brownout_active_fuse;
  // A comparator on the reference holds the reference whatever the sleep mode says.
  wire next_vref  = next_bod || (comp_req && comp_ref) || conv_req;
  wire [7:0] next_bufs = (!next_io && !next_conv) ? wake_pin_mask : 8'hFF;

  // Sleep sequence.
  // The timer's done flag is registered and costs one cycle, so every count is loaded one short.
  always_comb
  begin
    next_state = state;
    wake_start = 1'b0;
    wake_load  = 6'(smcg_pkg::IRQ_STALL_CYCLES - 1);
    case (state)
      SMCG_ACTIVE:
      begin
        if (sleep_instr && sleep_enable)
          next_state = SMCG_SLEEP;
      end
      SMCG_SLEEP:
      begin
        if (wake_irq)
        begin
          wake_start = 1'b1;
          if (mode_standby)
          begin
            next_state = SMCG_WAKE;
            wake_load  = 6'(smcg_pkg::STANDBY_WAKE_CYCLES - 1);
          end
          else if (mode_idle || mode_noise)
            next_state = SMCG_STALL;
          else
          begin
            next_state = SMCG_WAKE;
            wake_load  = 6'(smcg_pkg::OSC_START_CYCLES - 1);
          end
        end
      end
      SMCG_WAKE:
      begin
        if (wake_done)
        begin
          next_state = SMCG_STALL;
          wake_start = 1'b1;
        end
      end
      SMCG_STALL:
      begin
        if (wake_done)
          next_state = SMCG_ACTIVE;
      end
      default:
        next_state = SMCG_ACTIVE;
    endcase
  end

  smcg_wake_timer u_wake_timer
  (
    .mclk       (mclk),
    .resetn     (resetn),
    .start      (wake_start),
    .load_value (wake_load),
    .done       (wake_done)
  );

  // Only the clock stops; the peripheral's flops keep their values and resources.
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : gate_cells
      smcg_gate_cell u_cell
      (
        .mclk       (mclk),
        .resetn     (resetn),
        .gate_off   (peripheral_clock_gate[g]),
        .domain_run (periph_run),
        .clk_enable (cell_clk_en[g]),
        .access_ok  (cell_access_ok[g])
      );
    end
  endgenerate

  // Register file.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      core_sleep_control    <= smcg_pkg::CORE_RESET;
      peripheral_clock_gate <= smcg_pkg::GATE_RESET;
      analog_config         <= smcg_pkg::ACFG_RESET;
    end
    else
    begin
      if (wr_ok && sel_core)
        core_sleep_control <= avs_writedata[7:0] & smcg_pkg::CORE_WRITABLE_MASK;
      if (wr_ok && sel_gate)
        peripheral_clock_gate <= avs_writedata[7:0];
      if (wr_ok && sel_analog)
        analog_config <= avs_writedata[7:0] & smcg_pkg::ACFG_MASK;
    end
  end

  // One wait cycle per access: waitrequest drops in the cycle after the request appears.
  wire [31:0] read_mux = sel_core   ? {24'h000000, core_sleep_control} :
                         sel_gate   ? {24'h000000, peripheral_clock_gate} :
                         sel_status ? {24'h000000, converter_extended, comparator_en, 4'(state), asleep,
                                       conv_was_off} :
                         sel_analog ? {24'h000000, analog_config} : smcg_pkg::UNMAPPED_READ;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      answer_pending  <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      answer_pending  <= (avs_read || avs_write) && !answer_pending;
      avs_waitrequest <= !((avs_read || avs_write) && !answer_pending);
      avs_readdata    <= read_mux;
    end
  end

  // Converter tracking: an off-to-on turn makes the next conversion the long one.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      conv_was_off       <= 1'b1;
      converter_extended <= 1'b1;
    end
    else
    begin
      conv_was_off <= !conv_req;
      if (conv_req && conv_was_off)
        converter_extended <= 1'b1;
      else if (!conv_req)
        converter_extended <= 1'b0;
    end
  end

  // Outputs.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state            <= SMCG_ACTIVE;
      clk_cpu_en       <= 1'b1;
      clk_flash_en     <= 1'b1;
      clk_io_en        <= 1'b1;
      clk_conv_en      <= 1'b1;
      osc_en           <= 1'b1;
      periph_clk_en    <= 8'hFF;
      periph_access_ok <= 1'b0;
      converter_en     <= 1'b0;
      comparator_en    <= 1'b0;
      vref_en          <= 1'b0;
      brownout_en      <= 1'b0;
      brownout_sampled <= 1'b0;
      watchdog_run     <= 1'b0;
      input_buf_en     <= 8'hFF;
      core_stall       <= 1'b0;
      asleep           <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      clk_cpu_en       <= next_cpu;
      clk_flash_en     <= next_cpu;
      clk_io_en        <= next_io;
      clk_conv_en      <= next_conv && !gate_converter;
      osc_en           <= next_osc;
      periph_clk_en    <= cell_clk_en;
      periph_access_ok <= periph_access && cell_access_ok[periph_select];
      converter_en     <= conv_req;
      comparator_en    <= next_comp;
      vref_en          <= next_vref;
      brownout_en      <= next_bod;
      brownout_sampled <= (bod_fuse == smcg_pkg::BOD_SAMPLED);
      watchdog_run     <= watchdog_on;
      input_buf_en     <= next_bufs;
      core_stall       <= (next_state == SMCG_STALL) || (next_state == SMCG_WAKE);
      asleep           <= (next_state == SMCG_SLEEP);
    end
  end

endmodule

// [inc/smcg_pkg.sv]
// Package with register map, field layout, reset values and timing counts of the sleep and clock gate block.
package smcg_pkg;

  // Register word addresses on the Avalon-MM bus (byte addresses).
  localparam logic [3:0] ADDR_CORE_SLEEP_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PERIPHERAL_GATE    = 4'h4;
  localparam logic [3:0] ADDR_SLEEP_STATUS       = 4'h8;
  localparam logic [3:0] ADDR_ANALOG_CONFIG      = 4'hC;

  // Core sleep control fields.
  localparam int SLEEP_ENABLE_BIT   = 5;
  localparam int SLEEP_MODE_LSB     = 3;
  localparam logic [7:0] CORE_WRITABLE_MASK = 8'h38;
  localparam logic [7:0] CORE_RESET         = 8'h00;

  // Peripheral clock gate fields.
  localparam int GATE_TWO_WIRE      = 7;
  localparam int GATE_SERIAL_PORT_1 = 6;
  localparam int GATE_SERIAL_PORT_0 = 5;
  localparam int GATE_SPI_UNIT      = 4;
  localparam int GATE_TIMER_2       = 3;
  localparam int GATE_TIMER_1       = 2;
  localparam int GATE_TIMER_0       = 1;
  localparam int GATE_CONVERTER     = 0;
  localparam logic [7:0] GATE_RESET = 8'h00;

  // Analog configuration fields.
  localparam int ACFG_CONVERTER_ON  = 0;
  localparam int ACFG_COMPARATOR_ON = 1;
  localparam int ACFG_COMPARATOR_REF = 2;
  localparam logic [7:0] ACFG_MASK  = 8'h07;
  localparam logic [7:0] ACFG_RESET = 8'h00;

  // Sleep mode encodings.
  localparam logic [1:0] MODE_IDLE      = 2'h0;
  localparam logic [1:0] MODE_NOISE_RED = 2'h1;
  localparam logic [1:0] MODE_POWERDOWN = 2'h2;
  localparam logic [1:0] MODE_STANDBY   = 2'h3;

  // Brown-out fuse encodings.
  localparam logic [1:0] BOD_SAMPLED  = 2'h1;
  localparam logic [1:0] BOD_ENABLED  = 2'h2;

  // Wake timing, in clock cycles of the core.
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int IRQ_STALL_CYCLES    = 4;
  localparam int OSC_START_CYCLES    = 16;

  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// [hdl/smcg_wake_timer.sv]
// Down counter that times the wake-up sequence out of sleep.
`timescale 1ns/1ps
module smcg_wake_timer
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Control.
  input  wire logic       start,
  input  wire logic [5:0] load_value,
  // Status.
  output logic            done
);

  logic [5:0] count;
  logic       running;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      count   <= 6'h00;
      running <= 1'b0;
      done    <= 1'b0;
    end
    else if (start)
    begin
      count   <= load_value;
      running <= 1'b1;
      done    <= 1'b0;
    end
    else if (running)
    begin
      count   <= count - 6'h01;
      running <= (count != 6'h01);
      done    <= (count == 6'h01);
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule

// [hdl/smcg_gate_cell.sv]
// Glitch-free clock enable for one peripheral with a registered access permit.
`timescale 1ns/1ps
module smcg_gate_cell
(
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic resetn,
  // Control.
  input  wire logic gate_off,
  input  wire logic domain_run,
  // Results.
  output logic      clk_enable,
  output logic      access_ok
);

  // The enable changes only on a clock edge, so the downstream latch-free gate never truncates a pulse.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      clk_enable <= 1'b1;
      access_ok  <= 1'b1;
    end
    else
    begin
      clk_enable <= domain_run & ~gate_off;
      access_ok  <= ~gate_off;
    end
  end

endmodule

// [verif/smcg_sva.sv]
// Concurrent checks on the ports of the sleep and clock gate block.
`timescale 1ns/1ps
module smcg_sva
(
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        resetn,
  // Register bus.
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Core side.
  input wire logic        sleep_instr,
  input wire logic        watchdog_on,
  input wire logic [7:0]  wake_pin_mask,
  input wire logic        periph_access,
  // Results.
  input wire logic        clk_cpu_en,
  input wire logic        clk_io_en,
  input wire logic        clk_conv_en,
  input wire logic        osc_en,
  input wire logic [7:0]  periph_clk_en,
  input wire logic        periph_access_ok,
  input wire logic        comparator_en,
  input wire logic        watchdog_run,
  input wire logic [7:0]  input_buf_en,
  input wire logic        core_stall,
  input wire logic        asleep
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_answer;
    $rose(avs_read || avs_write) |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_core_zero;
    avs_read && !avs_waitrequest && avs_address == 4'h0 |-> (avs_readdata & 32'hFFFF_FFC7) == 32'h0000_0000;
  endproperty
  a_core_zero: assert property (p_core_zero) else $error("reserved core bits set");
  property p_access;
    periph_access_ok |-> $past(periph_access);
  endproperty
  a_access: assert property (p_access) else $error("access granted unasked");
  property p_deep_gate;
    !clk_io_en [*3] |-> periph_clk_en == 8'h00;
  endproperty
  a_deep_gate: assert property (p_deep_gate) else $error("peripheral clock runs without io clock");
  property p_comp_off;
    !osc_en [*3] |-> !comparator_en;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("comparator on in power-down");
  property p_pd_clocks;
    !osc_en [*3] |-> !clk_cpu_en && !clk_io_en && !clk_conv_en;
  endproperty
  a_pd_clocks: assert property (p_pd_clocks) else $error("clock runs in power-down");
  property p_buffers;
    input_buf_en == 8'hFF || input_buf_en == $past(wake_pin_mask);
  endproperty
  a_buffers: assert property (p_buffers) else $error("input buffers wrong");
  property p_watchdog;
    $past(resetn) |-> watchdog_run == $past(watchdog_on);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog run wrong");
  property p_entry;
    $rose(asleep) |-> $past(sleep_instr);
  endproperty
  a_entry: assert property (p_entry) else $error("sleep without instruction");
  c_sleep: cover property ($rose(asleep));
  c_stall: cover property ($fell(core_stall));
  c_access: cover property (periph_access_ok);
endmodule
bind smcg_top smcg_sva u_sva
(
  .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_instr(sleep_instr),
  .watchdog_on(watchdog_on), .wake_pin_mask(wake_pin_mask), .periph_access(periph_access),
  .clk_cpu_en(clk_cpu_en), .clk_io_en(clk_io_en), .clk_conv_en(clk_conv_en), .osc_en(osc_en),
  .periph_clk_en(periph_clk_en), .periph_access_ok(periph_access_ok), .comparator_en(comparator_en),
  .watchdog_run(watchdog_run), .input_buf_en(input_buf_en), .core_stall(core_stall), .asleep(asleep)
);

// [verif/tb.sv]
// Self-checking bench for the sleep and clock gate block.
`timescale 1ns/1ps
module tb;
  logic        mclk, resetn, avs_read, avs_write, avs_waitrequest, sleep_instr, wake_irq, periph_access;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [2:0]  periph_select;
  logic [7:0]  periph_clk_en, input_buf_en;
  logic        clk_cpu_en, clk_flash_en, clk_io_en, clk_conv_en, osc_en, periph_access_ok;
  logic        converter_en, converter_extended, comparator_en, vref_en, brownout_en, brownout_sampled;
  logic        watchdog_run, core_stall, asleep, wdog;
  logic [1:0]  bod_fuse;
  int          fail_count, tests_run, n;
  smcg_top u_dut
  (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sleep_instr(sleep_instr), .wake_irq(wake_irq), .watchdog_on(wdog),
    .brownout_sleep_fuse(bod_fuse), .brownout_active_fuse(2'h3), .wake_pin_mask(8'h05),
    .periph_access(periph_access), .periph_select(periph_select), .clk_cpu_en(clk_cpu_en),
    .clk_flash_en(clk_flash_en), .clk_io_en(clk_io_en), .clk_conv_en(clk_conv_en), .osc_en(osc_en),
    .periph_clk_en(periph_clk_en), .periph_access_ok(periph_access_ok), .converter_en(converter_en),
    .converter_extended(converter_extended), .comparator_en(comparator_en), .vref_en(vref_en),
    .brownout_en(brownout_en), .brownout_sampled(brownout_sampled), .watchdog_run(watchdog_run),
    .input_buf_en(input_buf_en), .core_stall(core_stall), .asleep(asleep)
  );
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The request is held until waitrequest is seen low, so an answer latency of up to 48 cycles is tolerated.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50)
    begin
      fail_count++;
      $display("CHECK FAILED bus answer expected %0d seen %0d", 1, k);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    #1;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end
  initial
  begin
    {resetn, avs_read, avs_write, sleep_instr, wake_irq, periph_access} = '0;
    {avs_address, avs_byteenable, avs_writedata, periph_select} = '0;
    wdog = 1'b1;
    bod_fuse = 2'h2;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk("periph_clk_en", 32'hFF, periph_clk_en);
    bus(1'b0, 4'h4, 8'h00, 4'hF);
    chk("gate reset", 32'h0, rd);
    bus(1'b1, 4'h0, 8'hFF, 4'hF);
    bus(1'b1, 4'h0, 8'h00, 4'h0);
    bus(1'b0, 4'h0, 8'h00, 4'hF);
    chk("core read", 32'h38, rd);
    bus(1'b1, 4'h0, 8'h00, 4'hF);
    bus(1'b0, 4'h2, 8'h00, 4'hF);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, 4'h8, 8'h00, 4'hF);
    chk("status", 32'h05, rd);
    $display("register test done");
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 4'h4, 8'h01 << i, 4'hF);
      cyc(3);
      chk("periph_clk_en", {24'h0, ~(8'h01 << i)}, periph_clk_en);
      @(posedge mclk);
      periph_access <= 1'b1;
      periph_select <= 3'(i);
      cyc(2);
      chk("access gated", 32'h0, periph_access_ok);
      @(posedge mclk);
      periph_select <= 3'(i ^ 1);
      cyc(2);
      chk("access open", 32'h1, periph_access_ok);
      @(posedge mclk);
      periph_access <= 1'b0;
      bus(1'b1, 4'h4, 8'h00, 4'hF);
      cyc(3);
      chk("ungated", 32'hFF, periph_clk_en);
    end
    $display("gate test done");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 4'hC, 8'(32'h00060201 >> (8 * i)), 4'hF);
      cyc(3);
      chk("vref_en", 32'(i % 2 == 0), vref_en);
      chk("extended", 32'(i == 0), converter_extended);
    end
    bus(1'b1, 4'hC, 8'h02, 4'hF);
    bus(1'b1, 4'h4, 8'h01, 4'hF);
    cyc(3);
    chk("comparator gated", 32'h0, comparator_en);
    bus(1'b1, 4'h4, 8'h00, 4'hF);
    $display("analog test done");
    @(posedge mclk);
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    cyc(4);
    chk("asleep disabled", 32'h0, asleep);
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, 4'hC, 8'h03, 4'hF);
      bus(1'b1, 4'h0, 8'h20 | 8'(m << 3), 4'hF);
      @(posedge mclk);
      sleep_instr <= 1'b1;
      wdog <= 1'(m % 2);
      bod_fuse <= (m == 3) ? 2'h1 : 2'h2;
      @(posedge mclk);
      sleep_instr <= 1'b0;
      cyc(4);
      chk("asleep", 32'h1, asleep);
      chk("flash clock", 32'h0, clk_flash_en);
      chk("bod sampled", 32'(m == 3), brownout_sampled);
      chk("converter", 32'h1, converter_en);
      chk("comparator", 32'(m <= 1), comparator_en);
      chk("cpu clock", 32'h0, clk_cpu_en);
      chk("io clock", 32'(m == 0), clk_io_en);
      chk("conv clock", 32'(m <= 1), clk_conv_en);
      chk("oscillator", 32'(m != 2), osc_en);
      chk("periph clocks", (m == 0) ? 32'hFF : 32'h00, periph_clk_en);
      chk("input buffers", (m >= 2) ? 32'h05 : 32'hFF, input_buf_en);
      chk("watchdog", 32'(m % 2), watchdog_run);
      chk("brownout", 32'(m != 0), brownout_en);
      @(posedge mclk);
      wake_irq <= 1'b1;
      for (int k = 0; k < 40 && core_stall !== 1'b1; k++)
        @(posedge mclk);
      wake_irq <= 1'b0;
      n = 0;
      while (core_stall === 1'b1 && n < 60)
      begin
        @(posedge mclk);
        n++;
      end
      chk("stall cycles", (m == 3) ? 32'd10 : (m == 2) ? 32'd20 : 32'd4, n);
      cyc(2);
      chk("awake", 32'h0, asleep);
      bus(1'b1, 4'h0, 8'h00, 4'hF);
    end
    $display("sleep test done");
    summarize();
  end
endmodule
